// ### rtl/mbd_decoder.sv
`include "mbd_cfg.svh"
`default_nettype none
// Behaviour
// - E8-EF copy working register to accumulator, one byte, one cycle.
// - E5 direct, E6-E7 indirect, 74 immediate load accumulator, two cycles.
// - F8-FF, A8-AF, 78-7F write working register; 1/2/2 bytes, 2/3/2 cycles.
// - F5 and 88-8F write direct byte, two bytes, two cycles.
// - 85 direct to direct move, three bytes, three cycles.
// - 86-87 two bytes, 75 three bytes, direct write, three cycles.
// - F6-F7, A6-A7, 76-77 indirect write; 1/2/2 bytes, 2/3/2 cycles.
// - 90 loads sixteen-bit data pointer, three bytes, three cycles.
// - 93 code read via data pointer 7 cycles, 83 via PC 8; one byte.
// - E2-E3 read 5 cycles, F2-F3 write 4 cycles, eight-bit expanded RAM.
// - E0 read 6 cycles, F0 write 5 cycles, data-pointer expanded RAM.
// - C0 push five cycles, D0 pop four cycles, both two bytes.
// - C8-CF 1B/3c, C5 2B/4c, C6-C7 1B/4c accumulator swap.
// - D6-D7 swap low nibble with indirect byte, one byte, four cycles.
// - 80 short jump 2B/4c, 73 computed jump 1B/6c.
// - 60 branch acc zero, 70 nonzero; two bytes, 3 or 5 cycles.
// - 40 branch carry set, 50 clear; two bytes, 2 or 4 cycles.
// - 20, 30, 10 bit branches; three bytes, 4 or 6 cycles.
// - B4-BF compare branch unequal; three bytes, 4 or 6 cycles.
// - D8-DF 2B 3/5 cycles, D5 3B 4/6 cycles decrement branch.
// - 82, B0, 72, A0 carry logic with bit, two bytes, two cycles.
// - A2 bit to carry 2 cycles, 92 carry to bit 3; two bytes.
module mbd_decoder (
  input wire logic i_core_clk,                // core clock
  input wire logic i_resetn,                  // sync reset, active low
  input wire logic i_op_valid,                // opcode offered
  input wire logic [7:0] i_opcode,            // opcode byte
  input wire logic i_cond_taken,              // branch condition result
  output logic o_op_ready,                    // decoder can take an opcode
  output logic o_known,                       // opcode belongs to these groups
  output logic [1:0] o_len,                   // instruction length in bytes
  output logic [3:0] o_cycles,                // cycles charged to instruction
  output mbd_pkg::mbd_class_t o_class,        // operation class
  output logic [2:0] o_reg_sel,               // working/indirect register index
  output logic o_is_branch,                   // conditional branch
  output logic o_busy,                        // instruction executing
  output logic o_done                         // last cycle pulse
);
  // ==========================================================
  // decode table
  // forty-eight masked entries; the carry-to-bit store takes the extra hit bit
  localparam int N = 48;
  typedef struct packed {
    logic [7:0] code;
    logic [7:0] mask;
    logic [1:0] len;
    logic [3:0] cyc;
    logic [3:0] cyc_t;
    mbd_pkg::mbd_class_t cls;
  } mbd_entry_t;
  function automatic mbd_entry_t ent(input logic [7:0] c, input logic [7:0] m, input logic [1:0] l,
                                     input logic [3:0] n, input logic [3:0] t, input mbd_pkg::mbd_class_t k);
    ent = '{code: c, mask: m, len: l, cyc: n, cyc_t: t, cls: k};
  endfunction
  localparam mbd_pkg::mbd_class_t MV = mbd_pkg::MBD_CL_MOVE;
  localparam mbd_entry_t TBL [N] = '{
    // one-cycle accumulator copy from a working register
    // register to acc
    ent(`MBD_OP_MOV_A_WR, `MBD_MASK_WR, 2'h1, 4'h1, 4'h1, MV),

    // accumulator from direct, indirect and immediate sources
    // acc loads
    ent(`MBD_OP_MOV_A_DIR, `MBD_MASK_FULL, 2'h2, 4'h2, 4'h2, MV),
    ent(`MBD_OP_MOV_A_IND, `MBD_MASK_IND, 2'h1, 4'h2, 4'h2, MV),
    ent(`MBD_OP_MOV_A_IMM, `MBD_MASK_FULL, 2'h2, 4'h2, 4'h2, MV),

    // working register from accumulator, direct byte or immediate
    // register writes
    ent(`MBD_OP_MOV_WR_A, `MBD_MASK_WR, 2'h1, 4'h2, 4'h2, MV),
    ent(`MBD_OP_MOV_WR_DIR, `MBD_MASK_WR, 2'h2, 4'h3, 4'h3, MV),
    ent(`MBD_OP_MOV_WR_IMM, `MBD_MASK_WR, 2'h2, 4'h2, 4'h2, MV),

    // direct byte from accumulator or working register
    // direct writes
    ent(`MBD_OP_MOV_DIR_A, `MBD_MASK_FULL, 2'h2, 4'h2, 4'h2, MV),
    ent(`MBD_OP_MOV_DIR_WR, `MBD_MASK_WR, 2'h2, 4'h2, 4'h2, MV),

    // three-byte move between two direct locations
    // direct to direct
    ent(`MBD_OP_MOV_DIR_DIR, `MBD_MASK_FULL, 2'h3, 4'h3, 4'h3, MV),

    // direct byte from an indirect source or an immediate
    // direct from indirect or immediate
    ent(`MBD_OP_MOV_DIR_IND, `MBD_MASK_IND, 2'h2, 4'h3, 4'h3, MV),
    ent(`MBD_OP_MOV_DIR_IMM, `MBD_MASK_FULL, 2'h3, 4'h3, 4'h3, MV),

    // indirect byte from accumulator, direct byte or immediate
    // indirect writes
    ent(`MBD_OP_MOV_IND_A, `MBD_MASK_IND, 2'h1, 4'h2, 4'h2, MV),
    ent(`MBD_OP_MOV_IND_DIR, `MBD_MASK_IND, 2'h2, 4'h3, 4'h3, MV),
    ent(`MBD_OP_MOV_IND_IMM, `MBD_MASK_IND, 2'h2, 4'h2, 4'h2, MV),

    // sixteen-bit pointer load with a two-byte operand
    // data pointer load
    ent(`MBD_OP_LOAD_DP, `MBD_MASK_FULL, 2'h3, 4'h3, 4'h3, mbd_pkg::MBD_CL_LOAD_DP),

    // code table reads, slow because of the program fetch
    // code table reads
    ent(`MBD_OP_CODE_RD_DP, `MBD_MASK_FULL, 2'h1, 4'h7, 4'h7, mbd_pkg::MBD_CL_CODE_RD),
    ent(`MBD_OP_CODE_RD_PC, `MBD_MASK_FULL, 2'h1, 4'h8, 4'h8, mbd_pkg::MBD_CL_CODE_RD),

    // expanded RAM through an eight-bit pointer register
    // eight-bit expanded RAM
    ent(`MBD_OP_XRAM_RD_IND, `MBD_MASK_IND, 2'h1, 4'h5, 4'h5, mbd_pkg::MBD_CL_XRAM_RD),
    ent(`MBD_OP_XRAM_WR_IND, `MBD_MASK_IND, 2'h1, 4'h4, 4'h4, mbd_pkg::MBD_CL_XRAM_WR),

    // expanded RAM through the sixteen-bit data pointer
    // sixteen-bit expanded RAM
    ent(`MBD_OP_XRAM_RD_DP, `MBD_MASK_FULL, 2'h1, 4'h6, 4'h6, mbd_pkg::MBD_CL_XRAM_RD),
    ent(`MBD_OP_XRAM_WR_DP, `MBD_MASK_FULL, 2'h1, 4'h5, 4'h5, mbd_pkg::MBD_CL_XRAM_WR),

    // stack push and pop of a direct byte
    // stack
    ent(`MBD_OP_PUSH, `MBD_MASK_FULL, 2'h2, 4'h5, 4'h5, mbd_pkg::MBD_CL_PUSH),
    ent(`MBD_OP_POP, `MBD_MASK_FULL, 2'h2, 4'h4, 4'h4, mbd_pkg::MBD_CL_POP),

    // full-byte accumulator swap forms
    // accumulator swap
    ent(`MBD_OP_SWAP_WR, `MBD_MASK_WR, 2'h1, 4'h3, 4'h3, mbd_pkg::MBD_CL_SWAP),
    ent(`MBD_OP_SWAP_DIR, `MBD_MASK_FULL, 2'h2, 4'h4, 4'h4, mbd_pkg::MBD_CL_SWAP),
    ent(`MBD_OP_SWAP_IND, `MBD_MASK_IND, 2'h1, 4'h4, 4'h4, mbd_pkg::MBD_CL_SWAP),

    // low nibble swap with an indirect byte
    // low nibble swap
    ent(`MBD_OP_NIB_SWAP, `MBD_MASK_IND, 2'h1, 4'h4, 4'h4, mbd_pkg::MBD_CL_NIB_SWAP),

    // unconditional short and computed jumps
    // unconditional jumps
    ent(`MBD_OP_RELATIVE_SHORT_JUMP, `MBD_MASK_FULL, 2'h2, 4'h4, 4'h4, mbd_pkg::MBD_CL_JUMP),
    ent(`MBD_OP_JMP_DP, `MBD_MASK_FULL, 2'h1, 4'h6, 4'h6, mbd_pkg::MBD_CL_JUMP),

    // accumulator tests, taken count two above not taken
    // accumulator zero tests
    ent(`MBD_OP_BR_ZERO, `MBD_MASK_FULL, 2'h2, 4'h3, 4'h5, mbd_pkg::MBD_CL_BR_ACC),
    ent(`MBD_OP_BR_NONZERO, `MBD_MASK_FULL, 2'h2, 4'h3, 4'h5, mbd_pkg::MBD_CL_BR_ACC),

    // carry tests, shortest of the branch forms
    // carry tests
    ent(`MBD_OP_BR_CSET, `MBD_MASK_FULL, 2'h2, 4'h2, 4'h4, mbd_pkg::MBD_CL_BR_CARRY),
    ent(`MBD_OP_BR_CCLR, `MBD_MASK_FULL, 2'h2, 4'h2, 4'h4, mbd_pkg::MBD_CL_BR_CARRY),

    // bit tests, three bytes with the bit address
    // bit tests
    ent(`MBD_OP_BR_BSET, `MBD_MASK_FULL, 2'h3, 4'h4, 4'h6, mbd_pkg::MBD_CL_BR_BIT),
    ent(`MBD_OP_BR_BCLR, `MBD_MASK_FULL, 2'h3, 4'h4, 4'h6, mbd_pkg::MBD_CL_BR_BIT),
    ent(`MBD_OP_BR_BSET_CLR, `MBD_MASK_FULL, 2'h3, 4'h4, 4'h6, mbd_pkg::MBD_CL_BR_BIT),

    // compare branches, four operand forms
    // compare branches
    ent(`MBD_OP_CMP_A_DIR, `MBD_MASK_FULL, 2'h3, 4'h4, 4'h6, mbd_pkg::MBD_CL_CMP_BR),
    ent(`MBD_OP_CMP_A_IMM, `MBD_MASK_FULL, 2'h3, 4'h4, 4'h6, mbd_pkg::MBD_CL_CMP_BR),
    ent(`MBD_OP_CMP_WR_IMM, `MBD_MASK_WR, 2'h3, 4'h4, 4'h6, mbd_pkg::MBD_CL_CMP_BR),
    ent(`MBD_OP_CMP_IND_IMM, `MBD_MASK_IND, 2'h3, 4'h4, 4'h6, mbd_pkg::MBD_CL_CMP_BR),

    // decrement branches on a register or a direct byte
    // decrement branches
    ent(`MBD_OP_DEC_WR, `MBD_MASK_WR, 2'h2, 4'h3, 4'h5, mbd_pkg::MBD_CL_DEC_BR),
    ent(`MBD_OP_DEC_DIR, `MBD_MASK_FULL, 2'h3, 4'h4, 4'h6, mbd_pkg::MBD_CL_DEC_BR),

    // carry logic against a direct bit
    // carry logic
    ent(`MBD_OP_AND_C_BIT, `MBD_MASK_FULL, 2'h2, 4'h2, 4'h2, mbd_pkg::MBD_CL_CARRY_LOGIC),
    ent(`MBD_OP_AND_C_NBIT, `MBD_MASK_FULL, 2'h2, 4'h2, 4'h2, mbd_pkg::MBD_CL_CARRY_LOGIC),
    ent(`MBD_OP_OR_C_BIT, `MBD_MASK_FULL, 2'h2, 4'h2, 4'h2, mbd_pkg::MBD_CL_CARRY_LOGIC),
    ent(`MBD_OP_OR_C_NBIT, `MBD_MASK_FULL, 2'h2, 4'h2, 4'h2, mbd_pkg::MBD_CL_CARRY_LOGIC),

    // bit into carry; carry into bit sits outside the table
    // carry transfers
    ent(`MBD_OP_MOV_C_BIT, `MBD_MASK_FULL, 2'h2, 4'h2, 4'h2, mbd_pkg::MBD_CL_CARRY_XFER)
  };
  // carry into bit, matched on its own bit of the hit vector
  localparam mbd_entry_t XFER_OUT = ent(`MBD_OP_MOV_BIT_C, `MBD_MASK_FULL, 2'h2, 4'h3, 4'h3,
                                        mbd_pkg::MBD_CL_CARRY_XFER);

  // ==========================================================
  // per-entry match, one hot
  logic [N:0] hit;
  genvar g;
  generate
    for (g = 0; g < N; g++) begin : g_match
      assign hit[g] = ((i_opcode & TBL[g].mask) == TBL[g].code);
    end
  endgenerate
  assign hit[N] = (i_opcode == XFER_OUT.code);

  // select the matching entry
  mbd_entry_t sel;
  always_comb begin
    sel = '0;
    // unknown opcodes occupy one cycle, never a conditional count
    sel.cyc = 4'h1;
    sel.cyc_t = 4'h1;
    for (int k = 0; k < N; k++) begin
      if (hit[k]) begin
        sel = TBL[k];
      end
    end
    if (hit[N]) begin
      sel = XFER_OUT;
    end
  end

  // masks never overlap, so at most one hit bit is set
  wire logic known = |hit;
  // a branch is any entry whose two counts differ
  wire logic is_cond = (sel.cyc_t != sel.cyc);
  wire logic [3:0] cyc_eff = (is_cond && i_cond_taken) ? sel.cyc_t : sel.cyc;
  // accepted only while idle; busy cycles refuse new opcodes
  wire logic take = i_op_valid && o_op_ready;

  // ==========================================================
  // cycle sequencer
  mbd_pkg::mbd_state_t state_q, state_d;
  logic [3:0] left_q, left_d;
  logic [1:0] len_q;
  logic [3:0] cyc_q;
  logic [2:0] reg_q;
  logic known_q, br_q;
  mbd_pkg::mbd_class_t cls_q;

  // next state
  always_comb begin
    state_d = state_q;
    left_d = left_q;
    case (state_q)
      mbd_pkg::MBD_IDLE: begin
        // one-cycle opcodes never leave idle
        if (take && cyc_eff != 4'h1) begin
          state_d = mbd_pkg::MBD_BUSY;
          left_d = cyc_eff - 4'h1;
        end
      end
      mbd_pkg::MBD_BUSY: begin
        left_d = left_q - 4'h1;
        if (left_q == 4'h1) begin
          state_d = mbd_pkg::MBD_IDLE;
        end
      end
      default: begin
        state_d = mbd_pkg::MBD_IDLE;
      end
    endcase
  end

  // state registers
  // left counts the busy cycles still to run
  always_ff @(posedge i_core_clk) begin
    if (!i_resetn) begin
      state_q <= mbd_pkg::MBD_IDLE;
      left_q <= 4'h0;
    end else begin
      state_q <= state_d;
      left_q <= left_d;
    end
  end

  // latched decode results
  // unknown opcodes latch zero length, class none, one cycle
  always_ff @(posedge i_core_clk) begin
    if (!i_resetn) begin
      len_q <= 2'h0;
      cyc_q <= 4'h0;
      reg_q <= 3'h0;
      known_q <= 1'b0;
      br_q <= 1'b0;
      cls_q <= mbd_pkg::MBD_CL_NONE;
    end else if (take) begin
      len_q <= sel.len;
      cyc_q <= cyc_eff;
      reg_q <= (sel.mask == `MBD_MASK_IND) ? {2'h0, i_opcode[0]} : i_opcode[2:0];
      known_q <= known;
      br_q <= is_cond;
      cls_q <= sel.cls;
    end
  end

  // done pulse after the last cycle
  // done rises together with ready, one cycle wide
  logic done_q;
  always_ff @(posedge i_core_clk) begin
    if (!i_resetn) begin
      done_q <= 1'b0;
    end else begin
      done_q <= (take && cyc_eff == 4'h1) || (state_q == mbd_pkg::MBD_BUSY && left_q == 4'h1);
    end
  end

  // ready is combinational so one-cycle opcodes run back to back
  // decode outputs hold until the next accepted opcode
  assign o_op_ready = (state_q == mbd_pkg::MBD_IDLE);
  assign o_busy = (state_q == mbd_pkg::MBD_BUSY);
  assign o_done = done_q;
  assign o_len = len_q;
  assign o_cycles = cyc_q;
  assign o_class = cls_q;
  assign o_reg_sel = reg_q;
  assign o_known = known_q;
  assign o_is_branch = br_q;
endmodule
`default_nettype wire

// ### shared/mbd_cfg.svh
`ifndef MBD_CFG_SVH
`define MBD_CFG_SVH
// opcode bytes and match masks
`define MBD_OP_MOV_A_WR      8'hE8
`define MBD_OP_MOV_A_DIR     8'hE5
`define MBD_OP_MOV_A_IND     8'hE6
`define MBD_OP_MOV_A_IMM     8'h74
`define MBD_OP_MOV_WR_A      8'hF8
`define MBD_OP_MOV_WR_DIR    8'hA8
`define MBD_OP_MOV_WR_IMM    8'h78
`define MBD_OP_MOV_DIR_A     8'hF5
`define MBD_OP_MOV_DIR_WR    8'h88
`define MBD_OP_MOV_DIR_DIR   8'h85
`define MBD_OP_MOV_DIR_IND   8'h86
`define MBD_OP_MOV_DIR_IMM   8'h75
`define MBD_OP_MOV_IND_A     8'hF6
`define MBD_OP_MOV_IND_DIR   8'hA6
`define MBD_OP_MOV_IND_IMM   8'h76
`define MBD_OP_LOAD_DP       8'h90
`define MBD_OP_CODE_RD_DP    8'h93
`define MBD_OP_CODE_RD_PC    8'h83
`define MBD_OP_XRAM_RD_IND   8'hE2
`define MBD_OP_XRAM_RD_DP    8'hE0
`define MBD_OP_XRAM_WR_IND   8'hF2
`define MBD_OP_XRAM_WR_DP    8'hF0
`define MBD_OP_PUSH          8'hC0
`define MBD_OP_POP           8'hD0
`define MBD_OP_SWAP_WR       8'hC8
`define MBD_OP_SWAP_DIR      8'hC5
`define MBD_OP_SWAP_IND      8'hC6
`define MBD_OP_NIB_SWAP      8'hD6
`define MBD_OP_RELATIVE_SHORT_JUMP          8'h80
`define MBD_OP_JMP_DP        8'h73
`define MBD_OP_BR_ZERO       8'h60
`define MBD_OP_BR_NONZERO    8'h70
`define MBD_OP_BR_CSET       8'h40
`define MBD_OP_BR_CCLR       8'h50
`define MBD_OP_BR_BSET       8'h20
`define MBD_OP_BR_BCLR       8'h30
`define MBD_OP_BR_BSET_CLR   8'h10
`define MBD_OP_CMP_A_DIR     8'hB5
`define MBD_OP_CMP_A_IMM     8'hB4
`define MBD_OP_CMP_WR_IMM    8'hB8
`define MBD_OP_CMP_IND_IMM   8'hB6
`define MBD_OP_DEC_WR        8'hD8
`define MBD_OP_DEC_DIR       8'hD5
`define MBD_OP_AND_C_BIT     8'h82
`define MBD_OP_AND_C_NBIT    8'hB0
`define MBD_OP_OR_C_BIT      8'h72
`define MBD_OP_OR_C_NBIT     8'hA0
`define MBD_OP_MOV_C_BIT     8'hA2
`define MBD_OP_MOV_BIT_C     8'h92
`define MBD_MASK_WR          8'hF8
`define MBD_MASK_IND         8'hFE
`define MBD_MASK_FULL        8'hFF
`endif

// ### shared/mbd_pkg.sv
`default_nettype none
package mbd_pkg;
  // operation class of a decoded opcode
  typedef enum logic [4:0] {
    MBD_CL_NONE, MBD_CL_MOVE, MBD_CL_LOAD_DP, MBD_CL_CODE_RD, MBD_CL_XRAM_RD, MBD_CL_XRAM_WR,
    MBD_CL_PUSH, MBD_CL_POP, MBD_CL_SWAP, MBD_CL_NIB_SWAP, MBD_CL_JUMP, MBD_CL_BR_ACC,
    MBD_CL_BR_CARRY, MBD_CL_BR_BIT, MBD_CL_CMP_BR, MBD_CL_DEC_BR, MBD_CL_CARRY_LOGIC, MBD_CL_CARRY_XFER
  } mbd_class_t;
  // decoder sequencing state
  typedef enum logic {MBD_IDLE, MBD_BUSY} mbd_state_t;
endpackage
`default_nettype wire

// ### test/mbd_decoder_sva.sv
`default_nettype none
// ==========
// decode and timing checker
module mbd_decoder_sva (
  input wire logic i_core_clk, // core clock
  input wire logic i_resetn, // sync reset, active low
  input wire logic i_op_valid, // opcode offered
  input wire logic [7:0] i_opcode, // opcode byte
  input wire logic i_cond_taken, // branch condition
  input wire logic o_op_ready, // decoder idle
  input wire logic o_known, // opcode recognised
  input wire logic [1:0] o_len, // length in bytes
  input wire logic [3:0] o_cycles, // cycles charged
  input wire mbd_pkg::mbd_class_t o_class, // operation class
  input wire logic [2:0] o_reg_sel, // register index
  input wire logic o_is_branch, // conditional branch
  input wire logic o_busy, // executing
  input wire logic o_done // last cycle pulse
);
  default clocking cb @(posedge i_core_clk);
  endclocking
  default disable iff (!i_resetn);
  // opcode accepted, matched under a mask
  sequence take(logic [7:0] v, logic [7:0] m);
    i_op_valid && o_op_ready && ((i_opcode & m) == v);
  endsequence
  // ==========
  // assertions
  one_cycle_a: assert property (take(8'hE8, 8'hF8) |=> o_len == 2'h1 && o_cycles == 4'h1 && o_done)
    else $error("register copy timing wrong");
  load_dir_a: assert property (take(8'hE5, 8'hFF) |=> o_busy ##1 o_done && o_op_ready)
    else $error("direct load timing wrong");
  table_pc_a: assert property (take(8'h83, 8'hFF) |=> o_busy [*7] ##1 o_done)
    else $error("code read timing wrong");
  xram_dp_a: assert property (take(8'hE0, 8'hFF) |=> o_cycles == 4'h6 ##0 o_busy [*5] ##1 o_done)
    else $error("expanded read timing wrong");
  swap_wr_a: assert property (take(8'hC8, 8'hF8) |=> o_cycles == 4'h3 ##0 o_busy [*2] ##1 o_done)
    else $error("register swap timing wrong");
  acc_branch_a: assert property (take(8'h60, 8'hEF) ##0 i_cond_taken |=> o_is_branch && o_cycles == 4'h5)
    else $error("taken zero test count wrong");
  carry_branch_a: assert property (take(8'h40, 8'hEF) |=> o_cycles == ($past(i_cond_taken) ? 4'h4 : 4'h2))
    else $error("carry test count wrong");
  bit_branch_a: assert property (take(8'h20, 8'hEF) |=> o_len == 2'h3 &&
    o_cycles == ($past(i_cond_taken) ? 4'h6 : 4'h4)) else $error("bit test decode wrong");
  cmp_len_a: assert property (take(8'hB4, 8'hFC) |=> o_len == 2'h3 && o_is_branch && o_known)
    else $error("compare branch decode wrong");
  bit_store_a: assert property (take(8'h92, 8'hFF) |=> o_cycles == 4'h3 ##2 o_done)
    else $error("carry to bit timing wrong");
endmodule
bind mbd_decoder mbd_decoder_sva chk (.i_core_clk, .i_resetn, .i_op_valid, .i_opcode, .i_cond_taken,
  .o_op_ready, .o_known, .o_len, .o_cycles, .o_class, .o_reg_sel, .o_is_branch, .o_busy, .o_done);
`default_nettype wire

// ### test/mbd_decoder_tb.sv
`default_nettype none
module mbd_decoder_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic i_core_clk = 1'b0;
  logic i_resetn = 1'b0;
  logic i_op_valid = 1'b0;
  logic [7:0] i_opcode = 8'h00;
  logic i_cond_taken = 1'b0;
  logic o_op_ready, o_known, o_busy, o_done;
  logic [1:0] o_len;
  logic [3:0] o_cycles;
  logic o_is_branch;
  logic [2:0] o_reg_sel;
  mbd_pkg::mbd_class_t o_class;
  int n_errors = 0;
  int n_checks = 0;
  // entries: first, last opcode, length, cycles not taken, cycles taken
  logic [27:0] mv [28] = '{28'hE8EF111, 28'hE5E5222, 28'hE6E7122, 28'h7474222,
    28'hF8FF122, 28'hA8AF233, 28'h787F222, 28'hF5F5222, 28'h888F222, 28'h8585333,
    28'h8687233, 28'h7575333, 28'hF6F7122, 28'hA6A7233, 28'h7677222, 28'h9090333,
    28'h9393177, 28'h8383188, 28'hE2E3155, 28'hF2F3144, 28'hE0E0166, 28'hF0F0155,
    28'hC0C0255, 28'hD0D0244, 28'hC8CF133, 28'hC5C5244, 28'hC6C7144, 28'hD6D7144};
  logic [27:0] br [21] = '{28'h8080244, 28'h7373166, 28'h6060235, 28'h7070235,
    28'h4040224, 28'h5050224, 28'h2020346, 28'h3030346, 28'h1010346, 28'hB5B5346,
    28'hB4B4346, 28'hB8BF346, 28'hB6B7346, 28'hD8DF235, 28'hD5D5346, 28'h8282222,
    28'hB0B0222, 28'h7272222, 28'hA0A0222, 28'hA2A2222, 28'h9292233};
  // ==========
  // device under test and clock
  mbd_decoder uut (.i_core_clk, .i_resetn, .i_op_valid, .i_opcode, .i_cond_taken, .o_op_ready, .o_known,
    .o_len, .o_cycles, .o_class, .o_reg_sel, .o_is_branch, .o_busy, .o_done);
  always #10 i_core_clk = ~i_core_clk;
  // ==========
  // shared tasks
  task automatic ck(input string nm, input logic [3:0] e, input logic [3:0] s);
    n_checks++;
    if (s !== e) begin
      $display("ERROR %s expected %h seen %h", nm, e, s);
      n_errors++;
    end
  endtask
  task automatic ckc(input string nm, input mbd_pkg::mbd_class_t e, input mbd_pkg::mbd_class_t s);
    n_checks++;
    if (s !== e) begin
      $display("ERROR %s expected %0d seen %0d", nm, e, s);
      n_errors++;
    end
  endtask
  // expected register index: three bits for eight-wide forms, one for pairs, bit 3 set means unchecked
  function automatic logic [3:0] rsel(input logic [27:0] e, input int o);
    logic [7:0] span;
    span = e[19:12] - e[27:20];
    if (span == 8'h07) rsel = {1'b0, 3'(o)};
    else if (span == 8'h01) rsel = {3'h0, 1'(o)};
    else rsel = 4'h8;
  endfunction
  // offer one opcode, judge decode and the cycle of done
  task automatic op(input logic [7:0] c, input logic q, input logic [1:0] ln, input logic [3:0] n,
                    input logic br, input logic [3:0] rs);
    int k;
    @(posedge i_core_clk);
    #1;
    ck("done cleared", 4'h0, {3'h0, o_done});
    i_op_valid = 1'b1;
    i_opcode = c;
    i_cond_taken = q;
    @(posedge i_core_clk);
    #1;
    i_op_valid = 1'b0;
    ck("known", {3'h0, ln != 2'h0}, {3'h0, o_known});
    ck("len", {2'h0, ln}, {2'h0, o_len});
    ck("cycles", n, o_cycles);
    ck("branch flag", {3'h0, br}, {3'h0, o_is_branch});
    ck("class set", {3'h0, ln != 2'h0}, {3'h0, o_class != mbd_pkg::MBD_CL_NONE});
    if (!rs[3]) ck("register index", rs, {1'b0, o_reg_sel});
    ck("busy", {3'h0, n != 4'h1}, {3'h0, o_busy});
    k = 1;
    while (o_done !== 1'b1 && k < 15) begin
      @(posedge i_core_clk);
      #1;
      k++;
    end
    ck("done cycle", n, k[3:0]);
    ck("ready at done", 4'h1, {3'h0, o_op_ready});
  endtask
  // every opcode of an entry, condition false then true
  task automatic run_entry(input logic [27:0] e);
    for (int o = int'(e[27:20]); o <= int'(e[19:12]); o++) begin
      op(8'(o), 1'b0, e[9:8], e[7:4], e[7:4] != e[3:0], rsel(e, o));
      op(8'(o), 1'b1, e[9:8], e[3:0], e[7:4] != e[3:0], rsel(e, o));
    end
  endtask
  // ==========
  // scenarios
  task automatic t_move;
    foreach (mv[i]) run_entry(mv[i]);
    $display("move group test done");
  endtask
  task automatic t_branch;
    foreach (br[i]) run_entry(br[i]);
    $display("branch group test done");
  endtask
  // unknown opcode, then opcode offered while busy is refused until idle, then accepted
  task automatic t_busy;
    op(8'h24, 1'b0, 2'h0, 4'h1, 1'b0, 4'h8);
    @(posedge i_core_clk);
    #1;
    i_op_valid = 1'b1;
    i_opcode = 8'h83;
    @(posedge i_core_clk);
    #1;
    i_opcode = 8'hE5;
    repeat (6) @(posedge i_core_clk);
    #1;
    ck("ready while busy", 4'h0, {3'h0, o_op_ready});
    ck("cycles while busy", 4'h8, o_cycles);
    ckc("class while busy", mbd_pkg::MBD_CL_CODE_RD, o_class);
    repeat (2) @(posedge i_core_clk);
    #1;
    i_op_valid = 1'b0;
    ck("len after busy", 4'h2, {2'h0, o_len});
    ckc("class after busy", mbd_pkg::MBD_CL_MOVE, o_class);
    repeat (2) @(posedge i_core_clk);
    $display("refusal test done");
  endtask
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  // main sequence
  initial begin
    repeat (20) @(posedge i_core_clk);
    #1;
    i_resetn = 1'b1;
    ck("ready after reset", 4'h1, {3'h0, o_op_ready});
    t_move();
    t_branch();
    t_busy();
    give_verdict();
  end
  // watchdog
  initial begin
    repeat (10000) @(posedge i_core_clk);
    n_errors++;
    give_verdict();
  end
endmodule
`default_nettype wire
